// [gdi_regs.svh]
// Constants for the instrument bus device interface.
// Assumes a 10 MHz system clock; command bytes compare on seven bits.
`ifndef GDI_REGS_SVH
`define GDI_REGS_SVH

// ==========================================================================
// Address group codes
`define GDI_LAG_BASE   7'h20
`define GDI_TAG_BASE   7'h40
`define GDI_UNL        7'h3F
`define GDI_UNT        7'h5F
`define GDI_SCG_BASE   7'h60
`define GDI_GRP_MASK   7'h60

// ==========================================================================
// Universal and addressed command codes
`define GDI_GTL        7'h01
`define GDI_SDC        7'h04
`define GDI_GET        7'h08
`define GDI_LLO        7'h11
`define GDI_DCL        7'h14
`define GDI_SPE        7'h18
`define GDI_SPD        7'h19

// ==========================================================================
// Status byte field and reset values
`define GDI_RQS_BIT    6
`define GDI_RQS_MASK   8'h40
`define GDI_PIN_IDLE   16'hFFFF

// ==========================================================================
// Timing
`define GDI_CLK_MHZ    10
`define GDI_SETTLE_NS  2000
`define GDI_SETTLE_CYC ((`GDI_SETTLE_NS * `GDI_CLK_MHZ + 999) / 1000)

`endif

// [gdi_pkg.sv]
// Types shared by the instrument bus device interface.
// Assumes gdi_regs.svh supplies the numeric constants.
package gdi_pkg;

    // Bus lines after synchronising, each bit high when the line is true.
    typedef struct packed {
        logic [7:0] dio;
        logic       atn;
        logic       eoi;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       ifc;
        logic       ren;
        logic       srq;
    } gdi_bus_t;

    // One byte with its end mark, used on both user streams.
    typedef struct packed {
        logic       valid;
        logic       eoi;
        logic [7:0] data;
    } gdi_byte_t;

    // Interface state shown to the instrument.
    typedef struct packed {
        logic remote;
        logic lockout;
        logic talk;
        logic listen;
        logic spoll;
        logic srq_line;
    } gdi_state_t;

    typedef enum logic [1:0] {
        AH_IDLE,
        AH_READY,
        AH_HOLD
    } gdi_ah_t;

    typedef enum logic [1:0] {
        SH_IDLE,
        SH_SETTLE,
        SH_VALID,
        SH_DONE
    } gdi_sh_t;

endpackage : gdi_pkg

// [gdi_device.sv]
// Device-side interface functions for a parallel instrument bus.
// Assumes bus pins arrive asynchronously and are open-drain, low is true;
// the instrument side runs on i_sys_clk.
`timescale 1ns/10ps
`include "gdi_regs.svh"

module gdi_device
    import gdi_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_dio_n,
    input  wire logic       i_atn_n,
    input  wire logic       i_ifc_n,
    input  wire logic       i_ren_n,
    input  wire logic       i_eoi_n,
    input  wire logic       i_dav_n,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    input  wire logic       i_srq_n,
    output logic      [7:0] o_dio_n,
    output logic      [7:0] o_dio_oe_n,
    output logic            o_eoi_n,
    output logic            o_eoi_oe_n,
    output logic            o_dav_n,
    output logic            o_dav_oe_n,
    output logic            o_nrfd_n,
    output logic            o_nrfd_oe_n,
    output logic            o_ndac_n,
    output logic            o_ndac_oe_n,
    output logic            o_srq_n,
    output logic            o_srq_oe_n,
    input  wire logic [4:0] i_my_addr,
    input  wire logic       i_talk_only,
    input  wire gdi_byte_t  i_tx,
    output logic            o_tx_taken,
    output gdi_byte_t       o_rx,
    input  wire logic       i_rx_ready,
    input  wire logic [7:0] i_status,
    input  wire logic       i_svc_req,
    output logic            o_trigger,
    output logic            o_dev_clear,
    output gdi_state_t      o_state
);

    // ======================================================================
    // Pin synchronisers
    // The controller lines are inputs only; there is no drive path for them.

    logic [15:0] sync1;
    logic [15:0] sync2;
    gdi_bus_t    bus;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sync1 <= `GDI_PIN_IDLE;
            sync2 <= `GDI_PIN_IDLE;
        end else begin
            sync1 <= {i_dio_n, i_atn_n, i_eoi_n, i_dav_n, i_nrfd_n,
                      i_ndac_n, i_ifc_n, i_ren_n, i_srq_n};
            sync2 <= sync1;
        end
    end

    assign bus = gdi_bus_t'(~sync2);

    // Interface clear returns talker, listener and handshakes to idle.
    logic clr;
    assign clr = i_reset | bus.ifc;

    // ======================================================================
    // Acceptor handshake

    gdi_ah_t    ah_state;
    logic       listen;
    logic       talk;
    logic       ah_active;
    logic       can_take;
    logic       ah_take;
    logic       cmd_take;
    logic [6:0] cmd;

    assign ah_active = bus.atn | listen;
    assign can_take  = bus.atn | i_rx_ready;
    assign ah_take   = (ah_state == AH_READY) & ah_active & can_take
                       & bus.dav;
    assign cmd_take  = ah_take & bus.atn;
    assign cmd       = bus.dio[6:0];

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            ah_state <= AH_IDLE;
        end else begin
            unique case (ah_state)
                AH_IDLE: begin
                    if (ah_active && !bus.dav) begin
                        ah_state <= AH_READY;
                    end
                end
                AH_READY: begin
                    if (!ah_active) begin
                        ah_state <= AH_IDLE;
                    end else if (ah_take) begin
                        ah_state <= AH_HOLD;
                    end
                end
                AH_HOLD: begin
                    // Waiting for data valid to drop stops a double take.
                    if (!bus.dav) begin
                        ah_state <= ah_active ? AH_READY : AH_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            o_nrfd_oe_n <= 1'b1;
            o_ndac_oe_n <= 1'b1;
        end else begin
            o_nrfd_oe_n <= !((ah_state == AH_READY && !can_take)
                             || ah_state == AH_HOLD);
            o_ndac_oe_n <= !(ah_state == AH_READY);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rx <= '0;
        end else begin
            o_rx.valid <= ah_take & !bus.atn;
            o_rx.eoi   <= bus.eoi;
            o_rx.data  <= bus.dio;
        end
    end

    // ======================================================================
    // Address and command decode
    // Bytes in the secondary group match none of the codes below, so they
    // leave the addressed state alone.

    logic [6:0] my_la;
    logic [6:0] my_ta;
    logic       spoll;
    logic       remote;
    logic       lockout;

    assign my_la = `GDI_LAG_BASE | {2'b00, i_my_addr};
    assign my_ta = `GDI_TAG_BASE | {2'b00, i_my_addr};

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            listen <= 1'b0;
        end else if (cmd_take) begin
            if (cmd == my_la) begin
                listen <= 1'b1;
            end else if (cmd == `GDI_UNL || cmd == my_ta) begin
                listen <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            talk <= 1'b0;
        end else if (cmd_take) begin
            if (cmd == my_ta) begin
                talk <= 1'b1;
            end else if (cmd == my_la) begin
                talk <= 1'b0;
            end else if ((cmd & `GDI_GRP_MASK) == `GDI_TAG_BASE) begin
                talk <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            spoll <= 1'b0;
        end else if (cmd_take && cmd == `GDI_SPE) begin
            spoll <= 1'b1;
        end else if (cmd_take && cmd == `GDI_SPD) begin
            spoll <= 1'b0;
        end
    end

    // Remote and lockout survive interface clear; only remote enable false
    // or an explicit go-to-local brings the instrument back to local.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !bus.ren) begin
            remote  <= 1'b0;
            lockout <= 1'b0;
        end else if (cmd_take) begin
            if (cmd == my_la) begin
                remote <= 1'b1;
            end else if (listen && cmd == `GDI_GTL) begin
                remote <= 1'b0;
            end
            if (cmd == `GDI_LLO) begin
                lockout <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_trigger   <= 1'b0;
            o_dev_clear <= 1'b0;
        end else begin
            o_trigger   <= cmd_take & listen & (cmd == `GDI_GET);
            o_dev_clear <= cmd_take & ((cmd == `GDI_DCL)
                           | (listen & (cmd == `GDI_SDC)));
        end
    end

    // ======================================================================
    // Service request

    logic rsv;
    logic stb_taken;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rsv <= 1'b0;
        end else if (i_svc_req) begin
            rsv <= 1'b1;
        end else if (stb_taken) begin
            rsv <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_srq_oe_n <= 1'b1;
        end else begin
            o_srq_oe_n <= !rsv;
        end
    end

    // ======================================================================
    // Source handshake

    gdi_sh_t    sh_state;
    gdi_byte_t  sh_byte;
    logic       sh_is_stb;
    logic       stb_sent;
    logic [7:0] cnt;
    logic       talk_active;
    logic       stb_mode;
    logic       sh_load;
    logic       sh_accepted;
    logic [7:0] stb;

    assign talk_active = (talk | i_talk_only) & !bus.atn;
    assign stb_mode    = spoll & talk;
    assign sh_load     = (sh_state == SH_IDLE) & talk_active
                         & (stb_mode ? !stb_sent : i_tx.valid);
    assign sh_accepted = (sh_state == SH_VALID) & talk_active & !bus.ndac;
    assign stb_taken   = sh_accepted & sh_is_stb;
    assign stb = (i_status & ~`GDI_RQS_MASK)
                 | (rsv ? `GDI_RQS_MASK : 8'h00);

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            sh_state  <= SH_IDLE;
            sh_byte   <= '0;
            sh_is_stb <= 1'b0;
            cnt       <= 8'h00;
        end else begin
            unique case (sh_state)
                SH_IDLE: begin
                    if (sh_load) begin
                        sh_state  <= SH_SETTLE;
                        sh_is_stb <= stb_mode;
                        sh_byte   <= stb_mode ? {1'b1, 1'b1, stb}
                                              : i_tx;
                        cnt       <= 8'(`GDI_SETTLE_CYC);
                    end
                end
                SH_SETTLE: begin
                    // Attention from the controller aborts the byte; an
                    // application byte is resent once talking resumes.
                    if (!talk_active) begin
                        sh_state <= SH_IDLE;
                    end else if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else if (!bus.nrfd) begin
                        sh_state <= SH_VALID;
                    end
                end
                SH_VALID: begin
                    if (!talk_active) begin
                        sh_state <= SH_IDLE;
                    end else if (!bus.ndac) begin
                        sh_state <= SH_DONE;
                    end
                end
                SH_DONE: begin
                    sh_state <= SH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (clr || !stb_mode) begin
            stb_sent <= 1'b0;
        end else if (stb_taken) begin
            stb_sent <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_tx_taken <= 1'b0;
        end else begin
            o_tx_taken <= sh_accepted & !sh_is_stb;
        end
    end

    // Drive only while talking with attention false, so a parallel poll
    // (attention with end) always finds these lines released.
    logic sh_drive;
    assign sh_drive = talk_active
                      & (sh_state == SH_SETTLE || sh_state == SH_VALID);

    always_ff @(posedge i_sys_clk) begin
        if (clr) begin
            o_dio_oe_n <= 8'hFF;
            o_eoi_oe_n <= 1'b1;
            o_dav_oe_n <= 1'b1;
        end else begin
            o_dio_oe_n <= sh_drive ? ~sh_byte.data : 8'hFF;
            o_eoi_oe_n <= !(sh_drive & sh_byte.eoi);
            o_dav_oe_n <= !(talk_active && sh_state == SH_VALID);
        end
    end

    // ======================================================================
    // Line levels and state outputs
    // Open-drain lines only ever pull low; the enables carry the data.

    logic line_low;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            line_low <= 1'b0;
            o_state  <= '0;
        end else begin
            line_low <= 1'b0;
            o_state  <= '{remote:   remote,
                          lockout:  lockout,
                          talk:     talk | i_talk_only,
                          listen:   listen,
                          spoll:    spoll,
                          srq_line: bus.srq};
        end
    end

    assign o_dio_n  = {8{line_low}};
    assign o_eoi_n  = line_low;
    assign o_dav_n  = line_low;
    assign o_nrfd_n = line_low;
    assign o_ndac_n = line_low;
    assign o_srq_n  = line_low;

endmodule : gdi_device

// [gdi_device_chk.sv]
// Concurrent checks on the device's bus pins and user outputs.
// Assumes it is bound to gdi_device; bus inputs are low-true pins.
`timescale 1ns/10ps

module gdi_device_chk
    import gdi_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_reset,
    input wire logic       i_atn_n,
    input wire logic       i_eoi_n,
    input wire logic       i_ren_n,
    input wire logic       i_nrfd_n,
    input wire logic       i_talk_only,
    input wire logic [7:0] o_dio_oe_n,
    input wire logic       o_eoi_oe_n,
    input wire logic       o_dav_oe_n,
    input wire logic       o_nrfd_oe_n,
    input wire logic       o_ndac_oe_n,
    input wire logic       o_trigger,
    input wire gdi_byte_t  o_rx,
    input wire gdi_state_t o_state
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // ======================================================================
    // Source side
    // An aborted byte may release its lines one edge after talk is lost.
    a_dio_talk: assert property (o_dio_oe_n != 8'hFF |->
        o_state.talk || $past(o_state.talk)) else $error("data not talker");
    a_dav_talk: assert property (!o_dav_oe_n || !o_eoi_oe_n |->
        o_state.talk || $past(o_state.talk)) else $error("dav not talker");
    // The pin reaches the decision through two flops and one more edge.
    a_dav_nrfd: assert property ($fell(o_dav_oe_n) |->
        $past(i_nrfd_n, 3)) else $error("dav before ready");
    a_ppoll_quiet: assert property ((!i_atn_n && !i_eoi_n)[*6] |->
        o_dio_oe_n == 8'hFF) else $error("data in parallel poll");

    // ======================================================================
    // Acceptor side and addressing
    a_rx_listen: assert property (o_rx.valid |-> o_state.listen)
        else $error("data taken unaddressed");
    // The line enables follow the take one edge after the data pulse.
    a_rx_hold: assert property (o_rx.valid |=>
        o_ndac_oe_n ##0 (!o_nrfd_oe_n)[*3]) else $error("nrfd not held");
    a_trig_listen: assert property (o_trigger |-> o_state.listen)
        else $error("trigger unaddressed");
    a_remote_ren: assert property ($rose(o_state.remote) |->
        o_state.listen && !i_ren_n) else $error("remote without ren");
    a_mla_untalk: assert property ($rose(o_state.listen) &&
        !i_talk_only |-> !o_state.talk) else $error("talk kept on mla");
    a_mta_unlisten: assert property ($rose(o_state.talk) &&
        !i_talk_only |-> !o_state.listen) else $error("listen kept");
endmodule : gdi_device_chk

// [gdi_ctrl_model.sv]
// Behavioural bus controller that is also the only other listener.
// Assumes the bench resolves open-drain wires with pull-ups.
`timescale 1ns/10ps

module gdi_ctrl_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_dio_n,
    input  wire logic       i_eoi_n,
    input  wire logic       i_dav_n,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    output logic      [7:0] o_dio_n,
    output logic            o_atn_n,
    output logic            o_eoi_n,
    output logic            o_dav_n,
    output logic            o_nrfd_n,
    output logic            o_ndac_n
);
    int n;

    // Idle it holds both acceptor lines low, so a talker cannot finish a
    // byte that nobody has taken.
    initial begin
        o_dio_n = 8'hFF;
        o_atn_n = 1'b1;
        o_eoi_n = 1'b1;
        o_dav_n = 1'b1;
        o_nrfd_n = 1'b0;
        o_ndac_n = 1'b0;
    end

    task automatic step;
        @(posedge i_sys_clk);
        #1;
    endtask : step

    task automatic atn(input logic a);
        step();
        o_atn_n = ~a;
    endtask : atn

    task automatic ppoll(input logic on);
        step();
        o_atn_n = ~on;
        o_eoi_n = ~on;
    endtask : ppoll

    task automatic send(input logic [7:0] b, input logic a, input logic e);
        atn(a);
        o_nrfd_n = 1'b1;
        o_ndac_n = 1'b1;
        for (n = 0; n < 300 && i_nrfd_n !== 1'b1; n++) step();
        o_dio_n = ~b;
        o_eoi_n = ~e;
        repeat (20) step();
        o_dav_n = 1'b0;
        step();
        for (n = 0; n < 300 && i_ndac_n !== 1'b1; n++) step();
        o_dav_n = 1'b1;
        o_dio_n = 8'hFF;
        o_eoi_n = 1'b1;
        o_nrfd_n = 1'b0;
        o_ndac_n = 1'b0;
    endtask : send

    task automatic take(output logic [8:0] eb);
        o_nrfd_n = 1'b1;
        for (n = 0; n < 300 && i_dav_n !== 1'b0; n++) step();
        eb = {~i_eoi_n, ~i_dio_n};
        o_nrfd_n = 1'b0;
        o_ndac_n = 1'b1;
        for (n = 0; n < 300 && i_dav_n !== 1'b1; n++) step();
        o_ndac_n = 1'b0;
    endtask : take
endmodule : gdi_ctrl_model

// [gdi_device_interface_functions_tb.sv]
// Self-checking bench: one task per scenario against the controller model.
// Assumes gdi_pkg, the design, its checker and gdi_ctrl_model are compiled.
`timescale 1ns/10ps

module gdi_device_interface_functions_tb
    import gdi_pkg::*;
;
    localparam logic [7:0] MLA = 8'h20 | 8'h0A;
    localparam logic [7:0] MTA = 8'h40 | 8'h0A;

    logic       clk = 1'b0, rst = 1'b1, ren_n = 1'b1, ifc_n = 1'b1;
    logic       svc = 1'b0, talk_only = 1'b0, rx_rdy = 1'b1;
    logic [4:0] addr = 5'h0A;
    logic [7:0] status = 8'h05;
    gdi_byte_t  tx = '0, rx, rx_last = '0;
    gdi_state_t st;
    int         checks = 0, err_total = 0, cyc = 0;
    int         n_rx = 0, n_trig = 0, n_clr = 0, n_tx = 0;
    logic [8:0] got;
    logic [7:0] m_dio, d_dio, d_dio_oe, dio_w;
    logic       m_atn, m_eoi, m_dav, m_nrfd, m_ndac, taken, trig, dclr;
    logic       d_eoi, d_eoi_oe, d_dav, d_dav_oe, d_nrfd, d_nrfd_oe;
    logic       d_ndac, d_ndac_oe, d_srq, d_srq_oe;
    logic       eoi_w, dav_w, nrfd_w, ndac_w, srq_w;

    assign dio_w = m_dio & (d_dio_oe | d_dio);
    assign eoi_w = m_eoi & (d_eoi_oe | d_eoi);
    assign dav_w = m_dav & (d_dav_oe | d_dav);
    assign nrfd_w = m_nrfd & (d_nrfd_oe | d_nrfd);
    assign ndac_w = m_ndac & (d_ndac_oe | d_ndac);
    assign srq_w = d_srq_oe | d_srq;

    initial forever #50 clk = ~clk;

    gdi_device dut_u (
        .i_sys_clk(clk), .i_reset(rst), .i_dio_n(dio_w), .i_atn_n(m_atn),
        .i_ifc_n(ifc_n), .i_ren_n(ren_n), .i_eoi_n(eoi_w), .i_dav_n(dav_w),
        .i_nrfd_n(nrfd_w), .i_ndac_n(ndac_w), .i_srq_n(srq_w),
        .o_dio_n(d_dio), .o_dio_oe_n(d_dio_oe), .o_eoi_n(d_eoi),
        .o_eoi_oe_n(d_eoi_oe), .o_dav_n(d_dav), .o_dav_oe_n(d_dav_oe),
        .o_nrfd_n(d_nrfd), .o_nrfd_oe_n(d_nrfd_oe), .o_ndac_n(d_ndac),
        .o_ndac_oe_n(d_ndac_oe), .o_srq_n(d_srq), .o_srq_oe_n(d_srq_oe),
        .i_my_addr(addr), .i_talk_only(talk_only), .i_tx(tx),
        .o_tx_taken(taken), .o_rx(rx), .i_rx_ready(rx_rdy),
        .i_status(status), .i_svc_req(svc), .o_trigger(trig),
        .o_dev_clear(dclr), .o_state(st));

    gdi_ctrl_model ctl_u (
        .i_sys_clk(clk), .i_dio_n(dio_w), .i_eoi_n(eoi_w), .i_dav_n(dav_w),
        .i_nrfd_n(nrfd_w), .i_ndac_n(ndac_w), .o_dio_n(m_dio),
        .o_atn_n(m_atn), .o_eoi_n(m_eoi), .o_dav_n(m_dav),
        .o_nrfd_n(m_nrfd), .o_ndac_n(m_ndac));

    // ======================================================================
    // Monitors and helpers
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rx.valid === 1'b1) begin
            n_rx <= n_rx + 1;
            rx_last <= rx;
        end
        if (trig === 1'b1) n_trig <= n_trig + 1;
        if (dclr === 1'b1) n_clr <= n_clr + 1;
        if (taken === 1'b1) begin
            n_tx <= n_tx + 1;
            tx <= '0;
        end
        if (cyc == 20000) begin
            err_total++;
            $display("CHECK FAILED timeout exp done got hung");
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input int exp, input logic [15:0] g);
        checks++;
        if (g !== 16'(exp)) begin
            err_total++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, g);
        end
    endtask : chk

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic cmd(input logic [7:0] b);
        ctl_u.send(b, 1'b1, 1'b0);
        repeat (4) step();
    endtask : cmd

    // ======================================================================
    // Scenarios
    task automatic t_listen;
        chk("reset state", 0, 16'(st));
        ren_n = 1'b0;
        cmd(8'h3F);
        cmd(MLA);
        chk("listen", 1, 16'(st.listen));
        chk("remote", 1, 16'(st.remote));
        cmd(8'h6A);
        chk("listen secondary", 1, 16'(st.listen));
        ctl_u.send(8'hA5, 1'b0, 1'b1);
        repeat (4) step();
        chk("rx byte", 'h1A5, {7'h00, rx_last.eoi, rx_last.data});
        chk("rx count", 1, 16'(n_rx));
        cmd(8'h3F);
        chk("unlisten", 0, 16'(st.listen));
        ctl_u.send(8'h5A, 1'b0, 1'b0);
        repeat (4) step();
        chk("rx refused", 1, 16'(n_rx));
        $display("test listen done");
    endtask : t_listen

    task automatic t_cmds;
        cmd(MLA);
        cmd(8'h08);
        chk("trigger", 1, 16'(n_trig));
        cmd(8'h04);
        chk("sdc", 1, 16'(n_clr));
        cmd(8'h11);
        chk("lockout", 1, 16'(st.lockout));
        cmd(8'h01);
        chk("local", 0, 16'(st.remote));
        cmd(8'h14);
        chk("dcl", 2, 16'(n_clr));
        cmd(MLA);
        cmd(8'h3F);
        cmd(8'h08);
        cmd(8'h04);
        cmd(8'h01);
        chk("unaddr get", 1, 16'(n_trig));
        chk("unaddr sdc", 2, 16'(n_clr));
        chk("unaddr gtl", 1, 16'(st.remote));
        $display("test commands done");
    endtask : t_cmds

    task automatic t_talk;
        cmd(MLA);
        cmd(MTA);
        chk("talk", 1, 16'(st.talk));
        chk("mta unlisten", 0, 16'(st.listen));
        tx = {1'b1, 1'b1, 8'h3C};
        ctl_u.atn(1'b0);
        ctl_u.take(got);
        repeat (4) step();
        chk("tx byte", 'h13C, 16'(got));
        chk("tx taken", 1, 16'(n_tx));
        cmd(MLA);
        chk("mla untalk", 0, 16'(st.talk));
        cmd(MTA);
        cmd(8'h4B);
        chk("ota untalk", 0, 16'(st.talk));
        cmd(MTA);
        cmd(8'h5F);
        chk("untalk", 0, 16'(st.talk));
        $display("test talk done");
    endtask : t_talk

    task automatic t_spoll;
        svc = 1'b1;
        step();
        svc = 1'b0;
        repeat (6) step();
        chk("srq", 1, 16'(st.srq_line));
        cmd(8'h18);
        chk("spoll on", 1, 16'(st.spoll));
        cmd(MTA);
        ctl_u.atn(1'b0);
        ctl_u.take(got);
        repeat (6) step();
        chk("status", 'h145, 16'(got));
        chk("srq off", 0, 16'(st.srq_line));
        cmd(8'h19);
        chk("spoll off", 0, 16'(st.spoll));
        cmd(8'h5F);
        $display("test serial poll done");
    endtask : t_spoll

    // The byte is left pending so the poll cuts a live source handshake; the
    // clear reaches the device with attention release and finds it idle.
    task automatic t_ifc;
        cmd(MTA);
        tx = {1'b1, 1'b0, 8'hC3};
        ctl_u.atn(1'b0);
        repeat (8) step();
        ctl_u.ppoll(1'b1);
        repeat (8) step();
        chk("ppoll data", 'hFF, 16'(d_dio_oe));
        ctl_u.ppoll(1'b0);
        ifc_n = 1'b0;
        repeat (3) step();
        ifc_n = 1'b1;
        repeat (4) step();
        chk("ifc talk", 0, 16'(st.talk));
        chk("ifc data", 'hFF, 16'(d_dio_oe));
        tx = '0;
        $display("test clear done");
    endtask : t_ifc

    // A listener that is not ready must hold the byte off, not drop it.
    task automatic t_ready;
        cmd(MLA);
        rx_rdy = 1'b0;
        ctl_u.atn(1'b0);
        repeat (4) step();
        fork
            ctl_u.send(8'h69, 1'b0, 1'b0);
            begin
                repeat (30) step();
                chk("nrfd held", 0, 16'(d_nrfd_oe));
                chk("rx held", 1, 16'(n_rx));
                rx_rdy = 1'b1;
            end
        join
        repeat (4) step();
        chk("rx late", 'h069, {7'h00, rx_last.eoi, rx_last.data});
        chk("rx count late", 2, 16'(n_rx));
        cmd(8'h3F);
        $display("test ready done");
    endtask : t_ready

    task automatic t_only;
        talk_only = 1'b1;
        tx = {1'b1, 1'b1, 8'h96};
        ctl_u.atn(1'b0);
        ctl_u.take(got);
        repeat (4) step();
        chk("talk only byte", 'h196, 16'(got));
        chk("talk only state", 1, 16'(st.talk));
        chk("talk only taken", 2, 16'(n_tx));
        talk_only = 1'b0;
        $display("test talk only done");
    endtask : t_only

    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_listen();
        t_cmds();
        t_talk();
        t_spoll();
        t_ifc();
        t_ready();
        t_only();
        final_report();
    end
endmodule : gdi_device_interface_functions_tb

bind gdi_device gdi_device_chk chk_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_atn_n(i_atn_n),
    .i_eoi_n(i_eoi_n), .i_ren_n(i_ren_n), .i_nrfd_n(i_nrfd_n),
    .i_talk_only(i_talk_only), .o_dio_oe_n(o_dio_oe_n),
    .o_eoi_oe_n(o_eoi_oe_n), .o_dav_oe_n(o_dav_oe_n),
    .o_nrfd_oe_n(o_nrfd_oe_n), .o_ndac_oe_n(o_ndac_oe_n),
    .o_trigger(o_trigger), .o_rx(o_rx), .o_state(o_state));
